/* rtl/bsfl_status.sv */
// Purpose: battery status word, cycle count and design capacity read words
// Assumes: an SMBus slave front end hands over one decoded command per pulse
// Notes: every flag and the error code sit in one status register
module bsfl_status (
	input wire logic CLK, // gauge clock, 125 MHz
	input wire logic RESET, // synchronous, active high
	input wire bsfl_pkg::bsfl_gauge_t GAUGE, // gauge quantities and events
	input wire bsfl_pkg::bsfl_cmd_t CMD, // decoded command from bus front end
	output logic RD_VALID, // one-cycle read answer strobe
	output logic [15:0] RD_DATA, // read answer word
	output bsfl_pkg::bsfl_status_t STATUS, // live status word
	output logic [15:0] CYCLE_COUNT, // live cycle count
	output logic NV_WR_VALID, // one-cycle nonvolatile save strobe
	output logic [7:0] NV_WR_ADDR, // nonvolatile save location
	output logic [15:0] NV_WR_DATA // nonvolatile save word
);
	import bsfl_pkg::*;
	bsfl_status_t stat_q;
	bsfl_status_t stat_d;
	logic [15:0] rem_prev_q;
	logic [15:0] att_prev_q;
	logic [15:0] cthr_prev_q;
	logic [15:0] tthr_prev_q;
	logic rd_valid_q;
	logic [15:0] rd_data_q;
	logic [15:0] cc_q;

	// unit selection for the alarm quantities and the design capacity answer
	wire [15:0] rem = GAUGE.cap_mode ? GAUGE.rem_p : GAUGE.rem_i;
	wire [15:0] tte = GAUGE.cap_mode ? GAUGE.tte_p : GAUGE.tte_i;
	wire [15:0] att = GAUGE.cap_mode ? GAUGE.att_p : GAUGE.att_i;
	wire [15:0] dcap_sel = GAUGE.cap_mode ? GAUGE.dcap_p : GAUGE.dcap_i;

	wire td_set = (rem == ZERO16) || (GAUGE.volt <= GAUGE.term_volt) || GAUGE.cell_uv;
	wire td_clr = (GAUGE.volt > GAUGE.term_volt) && (rem != ZERO16) && !GAUGE.cell_uv;

	// a bare crossing is not enough to clear: the threshold must drop or charging lift it
	wire rca_set = rem < GAUGE.cap_thr;
	wire cthr_down = GAUGE.cap_thr < cthr_prev_q;
	wire rem_up = GAUGE.charging && (rem > rem_prev_q);
	wire rca_clr = (GAUGE.cap_thr < rem) && (cthr_down || rem_up);

	wire rta_set = tte < GAUGE.time_thr;
	wire tthr_down = GAUGE.time_thr < tthr_prev_q;
	wire att_up = GAUGE.charging && (att > att_prev_q);
	wire rta_clr = (GAUGE.time_thr < att) && (tthr_down || att_up);

	wire fc_set = GAUGE.chg_term || GAUGE.overchg;
	wire fc_clr = GAUGE.rsoc < GAUGE.fc_clr_pct;

	wire [15:0] edv_v = GAUGE.use_cell ? GAUGE.cell_volt : GAUGE.volt;
	wire edv_low = (edv_v < GAUGE.second_end_discharge_threshold) && (GAUGE.current < GAUGE.ovld_cur);
	wire fd_set = edv_low || (GAUGE.rsoc < GAUGE.low_pct);
	wire fd_clr = GAUGE.rsoc >= FD_CLEAR_PCT;

	// command decode
	wire is_ours = (CMD.code == CMD_STATUS) || (CMD.code == CMD_CYCLE) || (CMD.code == CMD_DCAP);
	wire is_defined = (CMD.code <= CMD_DEF_LAST) || (CMD.code == CMD_PACK);
	wire is_word = CMD.code < CMD_BLOCK_FIRST;
	wire bad_size = CMD.write && is_word && (CMD.nbytes != WORD_BYTES);
	wire rd_ours = CMD.valid && !CMD.write && is_ours && !CMD.busy;
	wire [3:0] err_new =
		CMD.busy ? ERR_BUSY :
		!is_defined ? ERR_RESERVED :
		(!is_ours && !CMD.impl) ? ERR_UNSUPPORTED :
		(CMD.write && is_ours) ? ERR_WRITE_TO_READONLY :
		bad_size ? ERR_WRONG_BLOCK_SIZE :
		CMD.ovf ? ERR_OVER_UNDERFLOW :
		CMD.fault ? ERR_UNIDENTIFIED :
		ERR_OK;
	wire [15:0] rd_word =
		(CMD.code == CMD_STATUS) ? stat_q :
		(CMD.code == CMD_CYCLE) ? cc_q :
		dcap_sel;

	// next flag state; hardware set wins over a same-cycle clear
	always_comb begin
		stat_d = stat_q;
		stat_d.hi_rsvd = 4'h0;
		stat_d.rsvd10 = 1'b0;
		if (td_set)
			stat_d.term_dsg = 1'b1;
		else if (td_clr)
			stat_d.term_dsg = 1'b0;
		if (rca_set)
			stat_d.low_charge = 1'b1;
		else if (rca_clr)
			stat_d.low_charge = 1'b0;
		if (rta_set)
			stat_d.low_time = 1'b1;
		else if (rta_clr)
			stat_d.low_time = 1'b0;
		if (GAUGE.load_ok)
			stat_d.initialized = 1'b1;
		else if (GAUGE.load_bad)
			stat_d.initialized = 1'b0;
		stat_d.discharging = !GAUGE.charging;
		if (fc_set)
			stat_d.fully_charged = 1'b1;
		else if (fc_clr)
			stat_d.fully_charged = 1'b0;
		if (fd_set)
			stat_d.fully_discharged = 1'b1;
		else if (fd_clr)
			stat_d.fully_discharged = 1'b0;
		// the read takes the old word; only the error field follows the command
		if (CMD.valid)
			stat_d.err = err_new;
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			stat_q <= '0;
			rem_prev_q <= ZERO16;
			att_prev_q <= ZERO16;
			cthr_prev_q <= ZERO16;
			tthr_prev_q <= ZERO16;
		end else begin
			stat_q <= stat_d;
			rem_prev_q <= rem;
			att_prev_q <= att;
			cthr_prev_q <= GAUGE.cap_thr;
			tthr_prev_q <= GAUGE.time_thr;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= ZERO16;
		end else begin
			rd_valid_q <= rd_ours;
			if (rd_ours)
				rd_data_q <= rd_word;
		end
	end

	bsfl_cycle_ctr u_cycle (
		.clk(CLK),
		.reset(RESET),
		.load(GAUGE.load_ok),
		.load_val(GAUGE.cc_nv),
		.dsg_valid(GAUGE.dsg_valid),
		.dsg_amt(GAUGE.dsg_amt),
		.thr(GAUGE.cc_thr),
		.count_q(cc_q),
		.nv_wr_q(NV_WR_VALID),
		.nv_addr_q(NV_WR_ADDR),
		.nv_data_q(NV_WR_DATA)
	);

	assign RD_VALID = rd_valid_q;
	assign RD_DATA = rd_data_q;
	assign STATUS = stat_q;
	assign CYCLE_COUNT = cc_q;

	sequence s_rd_status;
		CMD.valid && !CMD.write && !CMD.busy && (CMD.code == CMD_STATUS);
	endsequence
	sequence s_rd_dcap;
		CMD.valid && !CMD.write && !CMD.busy && (CMD.code == CMD_DCAP);
	endsequence
	sequence s_rd_cycle;
		CMD.valid && !CMD.write && !CMD.busy && (CMD.code == CMD_CYCLE);
	endsequence

	property p_td_set;
		@(posedge CLK) disable iff (RESET)
		(rem == ZERO16) |=> stat_q.term_dsg;
	endproperty
	a_td_set: assert property (p_td_set) else $error("stop alarm not set");
	property p_td_clr;
		@(posedge CLK) disable iff (RESET)
		$fell(stat_q.term_dsg) |-> $past(td_clr);
	endproperty
	a_td_clr: assert property (p_td_clr) else $error("stop alarm cleared early");
	property p_rca_set;
		@(posedge CLK) disable iff (RESET)
		rca_set |=> stat_q.low_charge;
	endproperty
	a_rca_set: assert property (p_rca_set) else $error("low charge alarm not set");
	property p_rca_clr;
		@(posedge CLK) disable iff (RESET)
		$fell(stat_q.low_charge) |-> $past(rca_clr);
	endproperty
	a_rca_clr: assert property (p_rca_clr) else $error("low charge alarm bad clear");
	property p_rta;
		@(posedge CLK) disable iff (RESET)
		rta_set |=> stat_q.low_time;
	endproperty
	a_rta: assert property (p_rta) else $error("low time alarm not set");
	property p_rta_clr;
		@(posedge CLK) disable iff (RESET)
		$fell(stat_q.low_time) |-> $past(rta_clr);
	endproperty
	a_rta_clr: assert property (p_rta_clr) else $error("low time alarm bad clear");
	property p_dsg;
		@(posedge CLK) disable iff (RESET)
		GAUGE.charging |=> !stat_q.discharging;
	endproperty
	a_dsg: assert property (p_dsg) else $error("discharging set while charging");
	property p_fd_clr;
		@(posedge CLK) disable iff (RESET)
		fd_clr && !fd_set |=> !stat_q.fully_discharged;
	endproperty
	a_fd_clr: assert property (p_fd_clr) else $error("fully discharged not cleared");
	property p_ro;
		@(posedge CLK) disable iff (RESET)
		CMD.valid && CMD.write && is_ours && !CMD.busy |=> stat_q.err == ERR_WRITE_TO_READONLY;
	endproperty
	a_ro: assert property (p_ro) else $error("read-only write not reported");
	property p_busy;
		@(posedge CLK) disable iff (RESET)
		CMD.valid && CMD.busy |=> (stat_q.err == ERR_BUSY) && !RD_VALID;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not reported");
	property p_snap;
		@(posedge CLK) disable iff (RESET)
		s_rd_status |=> RD_VALID && (RD_DATA == $past(stat_q));
	endproperty
	a_snap: assert property (p_snap) else $error("status read not a snapshot");
	property p_dcap;
		@(posedge CLK) disable iff (RESET)
		s_rd_dcap |=> RD_VALID && (RD_DATA == $past(dcap_sel)) ##1 (RD_VALID == $past(rd_ours));
	endproperty
	a_dcap: assert property (p_dcap) else $error("design capacity answer wrong");
	property p_td_cause;
		@(posedge CLK) disable iff (RESET)
		(GAUGE.volt <= GAUGE.term_volt) || GAUGE.cell_uv |=> stat_q.term_dsg;
	endproperty
	a_td_cause: assert property (p_td_cause) else $error("stop alarm missed low voltage");
	property p_td_good;
		@(posedge CLK) disable iff (RESET)
		td_clr |=> !stat_q.term_dsg;
	endproperty
	a_td_good: assert property (p_td_good) else $error("stop alarm held while all good");
	property p_rca_drop;
		@(posedge CLK) disable iff (RESET)
		rca_clr && !rca_set |=> !stat_q.low_charge;
	endproperty
	a_rca_drop: assert property (p_rca_drop) else $error("low charge alarm not cleared");
	property p_rta_drop;
		@(posedge CLK) disable iff (RESET)
		rta_clr && !rta_set |=> !stat_q.low_time;
	endproperty
	a_rta_drop: assert property (p_rta_drop) else $error("low time alarm not cleared");
	property p_unit_i;
		@(posedge CLK) disable iff (RESET)
		!GAUGE.cap_mode && (GAUGE.rem_i < GAUGE.cap_thr) |=> stat_q.low_charge;
	endproperty
	a_unit_i: assert property (p_unit_i) else $error("current unit charge alarm missed");
	property p_unit_p;
		@(posedge CLK) disable iff (RESET)
		GAUGE.cap_mode && (GAUGE.tte_p < GAUGE.time_thr) |=> stat_q.low_time;
	endproperty
	a_unit_p: assert property (p_unit_p) else $error("power unit time alarm missed");
	property p_init_set;
		@(posedge CLK) disable iff (RESET)
		GAUGE.load_ok |=> stat_q.initialized;
	endproperty
	a_init_set: assert property (p_init_set) else $error("initialized not set");
	property p_init_clr;
		@(posedge CLK) disable iff (RESET)
		GAUGE.load_bad && !GAUGE.load_ok |=> !stat_q.initialized;
	endproperty
	a_init_clr: assert property (p_init_clr) else $error("initialized not cleared");
	property p_dsg_set;
		@(posedge CLK) disable iff (RESET)
		!GAUGE.charging |=> stat_q.discharging;
	endproperty
	a_dsg_set: assert property (p_dsg_set) else $error("discharging not set");
	property p_fc_set;
		@(posedge CLK) disable iff (RESET)
		fc_set |=> stat_q.fully_charged;
	endproperty
	a_fc_set: assert property (p_fc_set) else $error("fully charged not set");
	property p_fc_clr;
		@(posedge CLK) disable iff (RESET)
		fc_clr && !fc_set |=> !stat_q.fully_charged;
	endproperty
	a_fc_clr: assert property (p_fc_clr) else $error("fully charged not cleared");
	property p_fd_set;
		@(posedge CLK) disable iff (RESET)
		fd_set |=> stat_q.fully_discharged;
	endproperty
	a_fd_set: assert property (p_fd_set) else $error("fully discharged not set");
	property p_fd_drop;
		@(posedge CLK) disable iff (RESET)
		$fell(stat_q.fully_discharged) |-> $past(fd_clr);
	endproperty
	a_fd_drop: assert property (p_fd_drop) else $error("fully discharged cleared early");
	property p_err_hold;
		@(posedge CLK) disable iff (RESET)
		!CMD.valid |=> $stable(stat_q.err);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error code moved without command");
	property p_ok;
		@(posedge CLK) disable iff (RESET)
		rd_ours && !CMD.ovf && !CMD.fault |=> stat_q.err == ERR_OK;
	endproperty
	a_ok: assert property (p_ok) else $error("clean read not reported ok");
	property p_size;
		@(posedge CLK) disable iff (RESET)
		CMD.valid && !CMD.busy && CMD.impl && !is_ours && bad_size |=>
			stat_q.err == ERR_WRONG_BLOCK_SIZE;
	endproperty
	a_size: assert property (p_size) else $error("wrong block size not reported");
	property p_rsvd;
		@(posedge CLK) disable iff (RESET)
		CMD.valid && !CMD.busy && !is_defined |=> stat_q.err == ERR_RESERVED;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved code not reported");
	property p_unsup;
		@(posedge CLK) disable iff (RESET)
		CMD.valid && !CMD.busy && is_defined && !is_ours && !CMD.impl |=>
			stat_q.err == ERR_UNSUPPORTED;
	endproperty
	a_unsup: assert property (p_unsup) else $error("unsupported code not reported");
	property p_ovf;
		@(posedge CLK) disable iff (RESET)
		CMD.valid && !CMD.busy && is_defined && CMD.impl && !CMD.write && CMD.ovf |=>
			stat_q.err == ERR_OVER_UNDERFLOW;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not reported");
	property p_cycle;
		@(posedge CLK) disable iff (RESET)
		s_rd_cycle |=> RD_VALID && (RD_DATA == $past(cc_q));
	endproperty
	a_cycle: assert property (p_cycle) else $error("cycle count answer wrong");
	property p_rd_hold;
		@(posedge CLK) disable iff (RESET)
		!rd_ours |=> !RD_VALID && $stable(RD_DATA);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("answer without our read");
endmodule

/* inc/bsfl_pkg.sv */
// Purpose: shared constants and carriers for the battery status flag logic
// Assumes: one gauge clock, synchronous active-high reset
// Notes: status word layout follows the smart battery status word convention
package bsfl_pkg;
	// command codes answered by this block
	localparam logic [7:0] CMD_STATUS = 8'h16;
	localparam logic [7:0] CMD_CYCLE = 8'h17;
	localparam logic [7:0] CMD_DCAP = 8'h18;
	// first block-sized code; codes below it carry one word
	localparam logic [7:0] CMD_BLOCK_FIRST = 8'h20;
	// last defined standard code and the one defined manufacturer code
	localparam logic [7:0] CMD_DEF_LAST = 8'h23;
	localparam logic [7:0] CMD_PACK = 8'h2f;
	localparam logic [5:0] WORD_BYTES = 6'h02;
	// error codes in the low nibble of the status word
	localparam logic [3:0] ERR_OK = 4'h0;
	localparam logic [3:0] ERR_BUSY = 4'h1;
	localparam logic [3:0] ERR_RESERVED = 4'h2;
	localparam logic [3:0] ERR_UNSUPPORTED = 4'h3;
	localparam logic [3:0] ERR_WRITE_TO_READONLY = 4'h4;
	localparam logic [3:0] ERR_OVER_UNDERFLOW = 4'h5;
	localparam logic [3:0] ERR_WRONG_BLOCK_SIZE = 4'h6;
	localparam logic [3:0] ERR_UNIDENTIFIED = 4'h7;
	// nonvolatile home of the cycle count word
	localparam logic [7:0] NV_CC_ADDR = 8'h0c;
	localparam logic [6:0] FD_CLEAR_PCT = 7'h14;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] CC_MAX = 16'hffff;
	localparam logic [15:0] CC_ONE = 16'h0001;
	typedef struct packed {
		logic [3:0] hi_rsvd;
		logic term_dsg;
		logic rsvd10;
		logic low_charge;
		logic low_time;
		logic initialized;
		logic discharging;
		logic fully_charged;
		logic fully_discharged;
		logic [3:0] err;
	} bsfl_status_t;
	typedef struct packed {
		logic cap_mode;
		logic [15:0] rem_i;
		logic [15:0] rem_p;
		logic [15:0] cap_thr;
		logic [15:0] tte_i;
		logic [15:0] tte_p;
		logic [15:0] att_i;
		logic [15:0] att_p;
		logic [15:0] time_thr;
		logic [15:0] volt;
		logic [15:0] term_volt;
		logic [15:0] cell_volt;
		logic [15:0] second_end_discharge_threshold;
		logic use_cell;
		logic cell_uv;
		logic signed [15:0] current;
		logic signed [15:0] ovld_cur;
		logic [6:0] rsoc;
		logic [6:0] fc_clr_pct;
		logic [6:0] low_pct;
		logic charging;
		logic load_ok;
		logic load_bad;
		logic chg_term;
		logic overchg;
		logic [15:0] dcap_i;
		logic [15:0] dcap_p;
		logic dsg_valid;
		logic [15:0] dsg_amt;
		logic [15:0] cc_thr;
		logic [15:0] cc_nv;
	} bsfl_gauge_t;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic write;
		logic [5:0] nbytes;
		logic impl;
		logic busy;
		logic ovf;
		logic fault;
	} bsfl_cmd_t;
endpackage

/* rtl/bsfl_cycle_ctr.sv */
// Purpose: cycle counter driven by discharged charge, with nonvolatile save
// Assumes: dsg_amt is charge removed since the previous dsg_valid pulse
// Notes: a zero threshold stops counting instead of counting every pulse
module bsfl_cycle_ctr (
	input wire logic clk, // gauge clock
	input wire logic reset, // synchronous, active high
	input wire logic load, // preset count from nonvolatile copy
	input wire logic [15:0] load_val, // nonvolatile count
	input wire logic dsg_valid, // discharged charge sample
	input wire logic [15:0] dsg_amt, // charge in this sample
	input wire logic [15:0] thr, // charge per cycle
	output logic [15:0] count_q, // saturating cycle count
	output logic nv_wr_q, // one-cycle save strobe
	output logic [7:0] nv_addr_q, // save location
	output logic [15:0] nv_data_q // saved count
);
	import bsfl_pkg::*;
	logic [16:0] acc_q;
	logic [16:0] acc_sum;
	logic [16:0] acc_d;
	logic [15:0] count_d;
	logic step;
	logic upd;
	logic run;
	assign run = dsg_valid && (thr != ZERO16);
	assign acc_sum = acc_q + {1'b0, dsg_amt};
	assign step = run && (acc_sum >= {1'b0, thr});
	assign acc_d = step ? acc_sum - {1'b0, thr} : (run ? acc_sum : acc_q);
	// hold at the top value: it means that many cycles or more
	assign count_d = (count_q == CC_MAX) ? CC_MAX : count_q + CC_ONE;
	assign upd = step && !load && (count_q != CC_MAX);
	always_ff @(posedge clk) begin
		if (reset) begin
			acc_q <= '0;
			count_q <= ZERO16;
			nv_wr_q <= 1'b0;
			nv_addr_q <= 8'h00;
			nv_data_q <= ZERO16;
		end else begin
			nv_wr_q <= upd;
			if (load) begin
				count_q <= load_val;
				acc_q <= '0;
			end else begin
				acc_q <= acc_d;
				if (step)
					count_q <= count_d;
			end
			if (upd) begin
				nv_addr_q <= NV_CC_ADDR;
				nv_data_q <= count_d;
			end
		end
	end
	property p_cc_sat;
		@(posedge clk) disable iff (reset)
		(count_q == CC_MAX) && !load |=> count_q == CC_MAX;
	endproperty
	a_cc_sat: assert property (p_cc_sat) else $error("cycle count left saturation");
	property p_cc_save;
		@(posedge clk) disable iff (reset)
		upd |=> nv_wr_q && (nv_data_q == count_q) && (nv_addr_q == NV_CC_ADDR);
	endproperty
	a_cc_save: assert property (p_cc_save) else $error("count update not saved");
	property p_cc_step;
		@(posedge clk) disable iff (reset)
		step && !load |=> count_q == $past(count_d);
	endproperty
	a_cc_step: assert property (p_cc_step) else $error("threshold crossing missed");
endmodule

/* sim/bsfl_host_model.sv */
// Purpose: host side of the command path, hands decoded requests to the block
// Assumes: a request changes one time unit after the rising edge
// Notes: reads are always word sized, as a host read-word transaction is
module bsfl_host_model (
	input wire logic clk, // gauge clock
	output bsfl_pkg::bsfl_cmd_t cmd // request to the block
);
	timeunit 1ns;
	timeprecision 1ps;
	import bsfl_pkg::*;
	initial cmd = '0;
	// one request per cycle; an all-zero request leaves the block idle
	task drive(input bsfl_cmd_t c);
		bsfl_cmd_t r;
		r = c;
		if (!r.write) r.nbytes = WORD_BYTES;
		@(posedge clk);
		#1;
		cmd = r;
	endtask
endmodule

/* sim/bsfl_status_test.sv */
// Purpose: self-checking bench for the battery status word block
// Assumes: gauge inputs and requests change 1 ns after the rising edge
// Notes: a cycle model runs beside the block and every output is compared
module bsfl_status_test;
	timeunit 1ns;
	timeprecision 1ps;
	import bsfl_pkg::*;
	localparam int N = 1000;
	localparam logic [7:0] CODES [9] = '{8'h16, 8'h17, 8'h18, 8'h05, 8'h1a, 8'h20, 8'h2f,
		8'h30, 8'h7f};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0;
	bsfl_gauge_t g;
	bsfl_cmd_t cmd;
	bsfl_status_t stat, es;
	logic rdv, nvv, erv, env;
	logic [15:0] rdd, cnt, nvd, erd, mcnt, rm, tt, at, prm, pat, pct, ptt;
	logic [7:0] nva;
	logic [31:0] sg = 32'h9d63_e446;
	logic [31:0] sc;
	int acc, miscompares, n_checks;
	always #4 clk = ~clk;
	bsfl_host_model bsfl_host_model_inst (.clk(clk), .cmd(cmd));
	bsfl_status bsfl_status_inst (.CLK(clk), .RESET(rst), .GAUGE(g), .CMD(cmd), .RD_VALID(rdv),
		.RD_DATA(rdd), .STATUS(stat), .CYCLE_COUNT(cnt), .NV_WR_VALID(nvv), .NV_WR_ADDR(nva),
		.NV_WR_DATA(nvd));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
	endfunction
	function automatic logic [15:0] s3(input logic [31:0] x, input int p);
		return 16'(x[p+:3]);
	endfunction
	function automatic logic [3:0] exp_err(input bsfl_cmd_t c);
		logic mine;
		mine = c.code >= CMD_STATUS && c.code <= CMD_DCAP;
		if (c.busy) return ERR_BUSY;
		if (c.code > CMD_DEF_LAST && c.code != CMD_PACK) return ERR_RESERVED;
		if (!mine && !c.impl) return ERR_UNSUPPORTED;
		if (c.write && mine) return ERR_WRITE_TO_READONLY;
		if (c.write && c.code < CMD_BLOCK_FIRST && c.nbytes != WORD_BYTES)
			return ERR_WRONG_BLOCK_SIZE;
		if (c.ovf) return ERR_OVER_UNDERFLOW;
		if (c.fault) return ERR_UNIDENTIFIED;
		return ERR_OK;
	endfunction
	// overflow and fault stay off our own reads, where the answer would be ambiguous
	function automatic bsfl_cmd_t mk(input logic [31:0] r);
		bsfl_cmd_t c;
		logic mine;
		c.code = CODES[r[3:0] % 9];
		mine = c.code >= CMD_STATUS && c.code <= CMD_DCAP;
		c.valid = r[4] | r[5];
		c.write = r[6] & r[7];
		c.nbytes = r[8] ? WORD_BYTES : 6'h03;
		c.impl = r[9];
		c.busy = r[12:10] == 3'h0;
		c.ovf = !mine && r[15:13] == 3'h0;
		c.fault = !mine && r[18:16] == 3'h0;
		return c;
	endfunction
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// unit switch only where both unit sets agree, so no alarm edge hangs on it
	task rand_gauge(input int k);
		logic [31:0] a, b;
		logic eq;
		a = nx(sg);
		b = nx(a);
		sg = b;
		eq = k % N < 2 || k % N >= N - 2;
		g.cap_mode = k >= N;
		g.rem_i = s3(a, 0);
		g.rem_p = eq ? g.rem_i : s3(a, 3);
		g.cap_thr = s3(a, 6);
		g.tte_i = s3(a, 9);
		g.tte_p = eq ? g.tte_i : s3(a, 12);
		g.att_i = s3(a, 15);
		g.att_p = eq ? g.att_i : s3(a, 18);
		g.time_thr = s3(a, 21);
		g.volt = s3(a, 24);
		g.term_volt = s3(a, 27);
		g.cell_volt = s3(b, 0);
		g.second_end_discharge_threshold = s3(b, 3);
		g.use_cell = b[6];
		g.cell_uv = b[9:7] == 3'h0;
		g.current = 16'(signed'(b[12:10]));
		g.ovld_cur = 16'(signed'(b[15:13]));
		g.rsoc = 7'h10 + 7'(b[18:16]);
		g.charging = b[19];
		g.load_ok = b[23:20] == 4'h0;
		g.load_bad = b[23:20] == 4'h1;
		g.chg_term = b[27:24] == 4'h0;
		g.overchg = b[27:24] == 4'h1;
		g.cc_nv = 16'(a ^ b);
	endtask
	always @(posedge clk) begin
		rm = g.cap_mode ? g.rem_p : g.rem_i;
		tt = g.cap_mode ? g.tte_p : g.tte_i;
		at = g.cap_mode ? g.att_p : g.att_i;
		erv <= 1'b0;
		env <= 1'b0;
		if (rst) begin
			es <= '0;
			erd <= 16'h0000;
			mcnt = 16'h0000;
			acc = 0;
		end else begin
			es.term_dsg <= rm == 0 || g.volt <= g.term_volt || g.cell_uv;
			es.low_charge <= rm < g.cap_thr || (es.low_charge &&
				!(g.cap_thr < rm && (g.cap_thr < pct || g.charging && rm > prm)));
			es.low_time <= tt < g.time_thr || (es.low_time &&
				!(g.time_thr < at && (g.time_thr < ptt || g.charging && at > pat)));
			es.initialized <= g.load_ok || (es.initialized && !g.load_bad);
			es.discharging <= !g.charging;
			es.fully_charged <= g.chg_term || g.overchg ||
				(es.fully_charged && !(g.rsoc < g.fc_clr_pct));
			es.fully_discharged <= ((g.use_cell ? g.cell_volt : g.volt) < g.second_end_discharge_threshold &&
				g.current < g.ovld_cur) || g.rsoc < g.low_pct ||
				(es.fully_discharged && g.rsoc < 7'h14);
			if (cmd.valid)
				es.err <= exp_err(cmd);
			if (cmd.valid && !cmd.write && !cmd.busy && cmd.code >= CMD_STATUS &&
				cmd.code <= CMD_DCAP) begin
				erv <= 1'b1;
				erd <= cmd.code == CMD_STATUS ? es : cmd.code == CMD_CYCLE ? mcnt :
					(g.cap_mode ? g.dcap_p : g.dcap_i);
			end
			if (g.load_ok) begin
				mcnt = g.cc_nv;
				acc = 0;
			end else if (g.dsg_valid && g.cc_thr != 0) begin
				acc += g.dsg_amt;
				if (acc >= g.cc_thr) begin
					acc -= g.cc_thr;
					if (mcnt != CC_MAX) begin
						mcnt++;
						env <= 1'b1;
					end
				end
			end
		end
		prm = rst ? 16'h0000 : rm;
		pat = rst ? 16'h0000 : at;
		pct = rst ? 16'h0000 : g.cap_thr;
		ptt = rst ? 16'h0000 : g.time_thr;
	end
	always @(negedge clk) begin
		if (go) begin
			chk(stat & 16'hfff0, es & 16'hfff0, "flags");
			chk(16'(stat.err), 16'(es.err), "error code");
			chk(16'(rdv), 16'(erv), "answer strobe");
			chk(rdd, erd, "answer word");
			chk(cnt, mcnt, "cycle count");
			chk(16'(nvv), 16'(env), "save strobe");
			if (env) begin
				chk(16'(nva), 16'(NV_CC_ADDR), "save place");
				chk(nvd, mcnt, "save word");
			end
		end
	end
	initial begin
		#(8 * 20000);
		miscompares++;
		print_verdict();
	end
	initial begin
		g = '0;
		g.dcap_i = 16'h1234;
		g.dcap_p = 16'h0abc;
		g.fc_clr_pct = 7'h13;
		g.low_pct = 7'h12;
		sc = ~sg;
		step(1);
		go = 1'b1;
		step(9);
		rst = 1'b0;
		// start two counts below the top so saturation is reached and held
		g.cc_nv = 16'hfffd;
		g.load_ok = 1'b1;
		step(1);
		g.load_ok = 1'b0;
		g.cc_thr = 16'h0064;
		g.dsg_amt = 16'h0064;
		g.dsg_valid = 1'b1;
		step(3);
		g.dsg_valid = 1'b0;
		g.cc_nv = 16'h0005;
		g.load_ok = 1'b1;
		step(1);
		g.load_ok = 1'b0;
		g.dsg_amt = 16'h003c;
		g.dsg_valid = 1'b1;
		step(5);
		g.cc_thr = 16'h0000;
		step(2);
		g.dsg_valid = 1'b0;
		// back-to-back reads, a refused write, then a busy read
		bsfl_host_model_inst.drive(mk(32'h0000_0411));
		bsfl_host_model_inst.drive(mk(32'h0000_0410));
		bsfl_host_model_inst.drive(mk(32'h0000_0412));
		bsfl_host_model_inst.drive(mk(32'h0000_04d0));
		bsfl_host_model_inst.drive(mk(32'h0000_0410));
		bsfl_host_model_inst.drive(mk(32'h0000_0010));
		bsfl_host_model_inst.drive('0);
		fork
			for (int k = 0; k < 2 * N; k++) begin
				rand_gauge(k);
				step(1);
			end
			repeat (2 * N) begin
				sc = nx(sc);
				bsfl_host_model_inst.drive(mk(sc));
			end
		join
		bsfl_host_model_inst.drive('0);
		step(3);
		print_verdict();
	end
endmodule
